// ===== core/nvmseq_top.sv
// data eeprom access sequencer with apb registers and byte array
`timescale 1ns/10ps
`default_nettype none
`include "nvmseq_map.svh"
module nvmseq_top (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  import nvmseq_pkg::*;

  // ==========================================
  // reset release
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  nvmseq_tmr_if tif ();
  nvmseq_wtimer u_tmr (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .tif   (tif)
  );

  // ==========================================
  // state
  nvmseq_byte_t  mem [256];
  nvmseq_byte_t  nvm_address_reg, nvm_address_next;
  nvmseq_byte_t  nvm_data_reg, nvm_data_next;
  nvmseq_byte_t  pointer_high_byte_reg, pointer_high_byte_next;
  nvmseq_byte_t  pointer_low_byte_reg, pointer_low_byte_next;
  logic [3:0]    nvm_control_reg, nvm_control_next;
  logic [2:0]    stat_reg, stat_next;
  logic [2:0]    mask_reg, mask_next;
  logic          lowpwr_reg, lowpwr_next;
  nvmseq_state_e st_reg, st_next;
  logic [7:0]    rcnt_reg, rcnt_next;
  logic [31:0]   prdata_reg, prdata_next;
  logic          pready_reg, pready_next;
  logic          pslverr_reg, pslverr_next;
  logic          irq_reg, irq_next;
  logic          mem_we;
  logic          start_w, abort_w;

  logic setup, wr_acc, ind_hit, mapped;
  logic [3:0] wctl;
  assign setup   = psel & ~penable & ~pready_reg;
  assign wr_acc  = setup & pwrite;
  // indirect port hits control register only when both the sector pointer and the low pointer byte select it
  assign ind_hit = (pointer_high_byte_reg == `NVMSEQ_CTL_SECTOR) &&
                   (pointer_low_byte_reg == `NVMSEQ_CTL_LOW);
  assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= `NVMSEQ_PWR_OFS);
  assign wctl    = pwdata[3:0];

  // ==========================================
  // next-state logic
  always_comb begin
    nvm_address_next       = nvm_address_reg;
    nvm_data_next          = nvm_data_reg;
    pointer_high_byte_next = pointer_high_byte_reg;
    pointer_low_byte_next  = pointer_low_byte_reg;
    nvm_control_next       = nvm_control_reg;
    stat_next              = stat_reg;
    mask_next              = mask_reg;
    lowpwr_next            = lowpwr_reg;
    st_next                = st_reg;
    rcnt_next              = rcnt_reg;
    prdata_next            = 32'h0000_0000;
    pready_next            = 1'b0;
    pslverr_next           = 1'b0;
    mem_we                 = 1'b0;
    start_w                = 1'b0;
    abort_w                = 1'b0;

    if (setup) begin
      pready_next  = 1'b1;
      pslverr_next = ~mapped;
    end
    if (wr_acc && mapped) begin
      case (paddr)
        `NVMSEQ_ADDR_OFS: nvm_address_next       = pwdata[7:0];
        `NVMSEQ_DATA_OFS: nvm_data_next          = pwdata[7:0];
        `NVMSEQ_PTRH_OFS: pointer_high_byte_next = pwdata[7:0];
        `NVMSEQ_PTRL_OFS: pointer_low_byte_next  = pwdata[7:0];
        `NVMSEQ_IND_OFS: begin
          if (ind_hit) begin
            nvm_control_next[`NVMSEQ_WRITE_PERMIT_BIT] = wctl[`NVMSEQ_WRITE_PERMIT_BIT];
            nvm_control_next[`NVMSEQ_READ_PERMIT_BIT] = wctl[`NVMSEQ_READ_PERMIT_BIT];
            // start bits cannot be cleared by software mid-cycle
            if (st_reg == NVMSEQ_IDLE) begin
              if (wctl[`NVMSEQ_WR_BIT] && nvm_control_reg[`NVMSEQ_WRITE_PERMIT_BIT]) begin
                nvm_control_next[`NVMSEQ_WR_BIT] = 1'b1;
                st_next = NVMSEQ_WRITE;
                start_w = 1'b1;
              end else if (wctl[`NVMSEQ_RD_BIT] && nvm_control_reg[`NVMSEQ_READ_PERMIT_BIT]) begin
                nvm_control_next[`NVMSEQ_RD_BIT] = 1'b1;
                st_next   = NVMSEQ_READ;
                rcnt_next = 8'(`NVMSEQ_READ_CYC);
              end
            end
          end
        end
        `NVMSEQ_STAT_OFS: stat_next = stat_reg & ~pwdata[2:0];
        `NVMSEQ_MASK_OFS: mask_next = pwdata[2:0];
        `NVMSEQ_PWR_OFS:  lowpwr_next = pwdata[0];
        default: ;
      endcase
    end

    case (st_reg)
      NVMSEQ_READ: begin
        if (lowpwr_next) begin
          st_next = NVMSEQ_IDLE;
          nvm_control_next[`NVMSEQ_RD_BIT] = 1'b0;
          stat_next[`NVMSEQ_ST_FAIL] = 1'b1;
        end else if (rcnt_reg == 8'h01) begin
          st_next = NVMSEQ_IDLE;
          nvm_data_next = mem[nvm_address_reg];
          nvm_control_next[`NVMSEQ_RD_BIT] = 1'b0;
          stat_next[`NVMSEQ_ST_RDONE] = 1'b1;
        end else begin
          rcnt_next = rcnt_reg - 8'h01;
        end
      end
      NVMSEQ_WRITE: begin
        if (lowpwr_next) begin
          st_next = NVMSEQ_IDLE;
          abort_w = 1'b1;
          nvm_control_next[`NVMSEQ_WR_BIT] = 1'b0;
          stat_next[`NVMSEQ_ST_FAIL] = 1'b1;
        end else if (tif.done) begin
          st_next = NVMSEQ_IDLE;
          mem_we  = 1'b1;
          nvm_control_next[`NVMSEQ_WR_BIT] = 1'b0;
          stat_next[`NVMSEQ_ST_WDONE] = 1'b1;
        end
      end
      default: st_next = st_next;
    endcase

    if (setup && !pwrite && mapped) begin
      case (paddr)
        `NVMSEQ_ADDR_OFS: prdata_next = {24'h000000, nvm_address_reg};
        `NVMSEQ_DATA_OFS: prdata_next = {24'h000000, nvm_data_reg};
        `NVMSEQ_PTRH_OFS: prdata_next = {24'h000000, pointer_high_byte_reg};
        `NVMSEQ_PTRL_OFS: prdata_next = {24'h000000, pointer_low_byte_reg};
        `NVMSEQ_IND_OFS:  prdata_next = ind_hit ? {28'h0000000, nvm_control_reg} : 32'h0;
        `NVMSEQ_STAT_OFS: prdata_next = {29'h0, stat_reg};
        `NVMSEQ_MASK_OFS: prdata_next = {29'h0, mask_reg};
        `NVMSEQ_PWR_OFS:  prdata_next = {31'h0, lowpwr_reg};
        default:          prdata_next = 32'h0000_0000;
      endcase
    end
    irq_next = |(stat_next & mask_next);
  end

  assign tif.start = start_w;
  assign tif.abort = abort_w;

  // ==========================================
  // registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_address_reg       <= 8'h00;
      nvm_data_reg          <= 8'h00;
      pointer_high_byte_reg <= 8'h00;
      pointer_low_byte_reg  <= 8'h00;
      nvm_control_reg       <= `NVMSEQ_CTL_RST;
      stat_reg              <= 3'h0;
      mask_reg              <= 3'h0;
      lowpwr_reg            <= 1'b0;
      st_reg                <= NVMSEQ_IDLE;
      rcnt_reg              <= 8'h00;
      prdata_reg            <= 32'h0000_0000;
      pready_reg            <= 1'b0;
      pslverr_reg           <= 1'b0;
      irq_reg               <= 1'b0;
    end else begin
      nvm_address_reg       <= nvm_address_next;
      nvm_data_reg          <= nvm_data_next;
      pointer_high_byte_reg <= pointer_high_byte_next;
      pointer_low_byte_reg  <= pointer_low_byte_next;
      nvm_control_reg       <= nvm_control_next;
      stat_reg              <= stat_next;
      mask_reg              <= mask_next;
      lowpwr_reg            <= lowpwr_next;
      st_reg                <= st_next;
      rcnt_reg              <= rcnt_next;
      prdata_reg            <= prdata_next;
      pready_reg            <= pready_next;
      pslverr_reg           <= pslverr_next;
      irq_reg               <= irq_next;
    end
  end

  // array has no reset
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[nvm_address_reg] <= nvm_data_reg;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;
endmodule
`default_nettype wire

// ===== shared/nvmseq_map.svh
// register offsets, field positions and timing constants of the nvm sequencer
`ifndef NVMSEQ_MAP_SVH
`define NVMSEQ_MAP_SVH
// apb byte addresses
`define NVMSEQ_ADDR_OFS      12'h000
`define NVMSEQ_DATA_OFS      12'h004
`define NVMSEQ_PTRH_OFS      12'h008
`define NVMSEQ_PTRL_OFS      12'h00C
`define NVMSEQ_IND_OFS       12'h010
`define NVMSEQ_STAT_OFS      12'h014
`define NVMSEQ_MASK_OFS      12'h018
`define NVMSEQ_PWR_OFS       12'h01C
// indirect location of the control register
`define NVMSEQ_CTL_SECTOR    8'h01
`define NVMSEQ_CTL_LOW       8'h40
// control bits
`define NVMSEQ_RD_BIT        0
`define NVMSEQ_READ_PERMIT_BIT      1
`define NVMSEQ_WR_BIT        2
`define NVMSEQ_WRITE_PERMIT_BIT      3
// status bits
`define NVMSEQ_ST_WDONE      0
`define NVMSEQ_ST_RDONE      1
`define NVMSEQ_ST_FAIL       2
// timing
`define NVMSEQ_READ_NS       100
`define NVMSEQ_CLK_MHZ       50
`define NVMSEQ_READ_CYC      ((`NVMSEQ_READ_NS * `NVMSEQ_CLK_MHZ + 999) / 1000)
`define NVMSEQ_WRITE_TICKS   16'h0040
`define NVMSEQ_TMR_DIV       8'h07
`define NVMSEQ_CTL_RST       4'h0
`endif

// ===== shared/nvmseq_pkg.sv
// types shared by the nvm sequencer modules
`default_nettype none
package nvmseq_pkg;
  typedef enum logic [1:0] {NVMSEQ_IDLE, NVMSEQ_READ, NVMSEQ_WRITE} nvmseq_state_e;
  typedef logic [7:0] nvmseq_byte_t;
endpackage
`default_nettype wire

// ===== shared/nvmseq_tmr_if.sv
// handshake between sequencer and the write timer
`timescale 1ns/10ps
`default_nettype none
interface nvmseq_tmr_if;
  logic start;
  logic abort;
  logic done;
  modport ctrl  (output start, output abort, input done);
  modport timer (input start, input abort, output done);
endinterface
`default_nettype wire

// ===== core/nvmseq_wtimer.sv
// write timer started per write, on its own free running slow tick, done resynchronised
`timescale 1ns/10ps
`default_nettype none
`include "nvmseq_map.svh"
module nvmseq_wtimer (
  input  wire logic     clk,
  input  wire logic     rst_n,
  nvmseq_tmr_if.timer   tif
);
  import nvmseq_pkg::*;
  logic [7:0]  div_reg, div_next;
  logic [15:0] cnt_reg, cnt_next;
  logic        run_reg, run_next;
  logic        fin_reg, fin_next;
  logic [1:0]  sync_reg, sync_next;
  logic        done_reg, done_next;

  // ==========================================
  // slow tick divider, free running
  always_comb begin
    div_next = (div_reg == `NVMSEQ_TMR_DIV) ? 8'h00 : div_reg + 8'h01;
    cnt_next = cnt_reg;
    run_next = run_reg;
    fin_next = 1'b0;
    if (tif.start) begin
      run_next = 1'b1;
      cnt_next = `NVMSEQ_WRITE_TICKS;
    end else if (tif.abort) begin
      run_next = 1'b0;
    end else if (run_reg && div_reg == 8'h00) begin
      if (cnt_reg == 16'h0001) begin
        run_next = 1'b0;
        fin_next = 1'b1;
      end
      cnt_next = cnt_reg - 16'h0001;
    end
    // completion stage then a two-stage resync before use
    sync_next = {sync_reg[0], fin_reg};
    done_next = sync_reg[1] & ~done_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg  <= 8'h00;
      cnt_reg  <= 16'h0000;
      run_reg  <= 1'b0;
      fin_reg  <= 1'b0;
      sync_reg <= 2'h0;
      done_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      cnt_reg  <= cnt_next;
      run_reg  <= run_next;
      fin_reg  <= fin_next;
      sync_reg <= sync_next;
      done_reg <= done_next;
    end
  end
  assign tif.done = done_reg;
endmodule
`default_nettype wire

// ===== bench/nvmseq_sva.sv
// assertion checker on the top ports of the nvm sequencer
`timescale 1ns/10ps
`default_nettype none
module nvmseq_sva (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  // ==========================================
  // apb answer timing and register map
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic setup;
  assign setup = psel && !penable;
  a_ready_after_setup: assert property (setup |=> pready) else $error("ready missing");
  a_ready_single: assert property (pready |=> !pready) else $error("ready too long");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray ready");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0) else $error("idle data");
  a_byte_wide_data: assert property (pready |-> prdata[31:8] == 24'h0) else $error("wide data");
  a_unmapped_err: assert property (setup && paddr > 12'h01C |=> pslverr)
    else $error("unmapped not refused");
  a_mapped_ok: assert property (setup && paddr <= 12'h01C && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped refused");
  a_irq_fall_write: assert property ($fell(irq) |-> $past(psel && pwrite) ||
    $past(psel && pwrite, 2) || $past(psel && pwrite, 3)) else $error("irq dropped alone");
endmodule
`default_nettype wire

// ===== bench/nvmseq_cpu_model.sv
// processor core model: apb master and software access sequences
`timescale 1ns/10ps
`default_nettype none
`include "nvmseq_map.svh"
module nvmseq_cpu_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic global_irq_enable = 1'b1;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
  endtask
  // ==========================================
  // permit then start on the next transfer
  task automatic start(input logic [7:0] a, input logic [31:0] perm);
    wr(`NVMSEQ_ADDR_OFS, {24'h0, a});
    wr(`NVMSEQ_PTRL_OFS, 32'h40);
    wr(`NVMSEQ_PTRH_OFS, 32'h1);
    global_irq_enable = 1'b0;
    wr(`NVMSEQ_IND_OFS, perm);
    wr(`NVMSEQ_IND_OFS, perm | perm >> 1);
    global_irq_enable = 1'b1;
  endtask
  task automatic finish(input int bit_no, output logic [31:0] first);
    logic [31:0] q;
    logic        e;
    int          i;
    xfer(1'b0, `NVMSEQ_IND_OFS, 32'h0, first, e);
    q = first;
    for (i = 0; i < 1000 && q[bit_no] === 1'b1; i++)
      xfer(1'b0, `NVMSEQ_IND_OFS, 32'h0, q, e);
    wr(`NVMSEQ_IND_OFS, 32'h0);
    wr(`NVMSEQ_PTRH_OFS, 32'h0);
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench of the nvm sequencer
`timescale 1ns/10ps
`default_nettype none
`include "nvmseq_map.svh"
module tb_top;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] c;
  logic        e;
  logic [7:0]  adr [4];
  logic [7:0]  mem [256];
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  always #10 ref_clk = ~ref_clk;
  nvmseq_top dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  nvmseq_cpu_model cpu (.clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  function automatic logic [31:0] ctl_word(input logic pw, sw, pr, sr);
    return {28'h0, pw, sw, pr, sr};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [11:0] ad, input logic [31:0] exp);
    logic [31:0] v;
    logic        er;
    cpu.xfer(1'b0, ad, 32'h0, v, er);
    chk(v, exp);
  endtask
  task automatic final_report;
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(8776));
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rchk(`NVMSEQ_PTRH_OFS, 32'h0);
    cpu.wr(`NVMSEQ_IND_OFS, 32'hA);
    cpu.wr(`NVMSEQ_PTRL_OFS, 32'h40);
    cpu.wr(`NVMSEQ_PTRH_OFS, 32'h1);
    rchk(`NVMSEQ_IND_OFS, 32'h0);
    cpu.wr(`NVMSEQ_IND_OFS, 32'h5);
    rchk(`NVMSEQ_IND_OFS, 32'h0);
    cpu.xfer(1'b0, 12'h020, 32'h0, c, e);
    chk(e, 1'b1);
    cpu.wr(`NVMSEQ_MASK_OFS, 32'h1);
    for (int i = 0; i < 4; i++) begin
      adr[i] = 8'($urandom);
      mem[adr[i]] = 8'($urandom);
      cpu.wr(`NVMSEQ_DATA_OFS, {24'h0, mem[adr[i]]});
      cpu.start(adr[i], 32'h8);
      cpu.finish(`NVMSEQ_WR_BIT, c);
      chk(c, ctl_word(1'b1, 1'b1, 1'b0, 1'b0));
      rchk(`NVMSEQ_STAT_OFS, 32'h1);
      chk(irq, 1'b1);
      cpu.wr(`NVMSEQ_STAT_OFS, 32'h1);
      rchk(`NVMSEQ_STAT_OFS, 32'h0);
      chk(irq, 1'b0);
    end
    for (int i = 3; i >= 0; i--) begin
      cpu.start(adr[i], 32'h2);
      cpu.finish(`NVMSEQ_RD_BIT, c);
      chk(c, ctl_word(1'b0, 1'b0, 1'b1, 1'b1));
      rchk(`NVMSEQ_DATA_OFS, {24'h0, mem[adr[i]]});
      rchk(`NVMSEQ_STAT_OFS, 32'h2);
      cpu.wr(`NVMSEQ_STAT_OFS, 32'h2);
    end
    // write aborted by a low-power request
    cpu.wr(`NVMSEQ_DATA_OFS, {24'h0, ~mem[adr[3]]});
    cpu.start(adr[3], 32'h8);
    cpu.wr(`NVMSEQ_PWR_OFS, 32'h1);
    rchk(`NVMSEQ_IND_OFS, ctl_word(1'b1, 1'b0, 1'b0, 1'b0));
    rchk(`NVMSEQ_STAT_OFS, 32'h4);
    cpu.wr(`NVMSEQ_PWR_OFS, 32'h0);
    cpu.wr(`NVMSEQ_STAT_OFS, 32'h7);
    cpu.start(adr[3], 32'h2);
    cpu.finish(`NVMSEQ_RD_BIT, c);
    rchk(`NVMSEQ_DATA_OFS, {24'h0, mem[adr[3]]});
    final_report();
  end
endmodule
bind nvmseq_top nvmseq_sva u_sva (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire
